// >>> inc/dsl_pkg.sv
// package for the serial-load and power-down logic of a single-channel dac
// assumes one 200 MHz system clock; frame pins arrive asynchronously
package dsl_pkg;
    // frame lengths and field layout
    localparam int NARROW_BITS = 16;
    localparam int WIDE_BITS = 24;
    localparam int NARROW_CODE_BITS = 14;
    localparam int WIDE_CODE_BITS = 16;
    localparam int NARROW_MODE_HI = 15;
    localparam int NARROW_MODE_LO = 14;
    localparam int WIDE_MODE_HI = 17;
    localparam int WIDE_MODE_LO = 16;
    localparam int WIDE_TOP_LO = 16;
    localparam logic [1:0] MODE_RESERVED_NARROW = 2'h3;
    // timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int EXIT_TIME_PS = 2500000;
    localparam int EXIT_CYCLES = EXIT_TIME_PS / CLK_PERIOD_PS;
    localparam int CODE_RESET = 0;

    // operating modes selected by the two mode bits
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_PD_OPEN = 2'b01,
        MODE_PD_100K = 2'b10,
        MODE_PD_1K = 2'b11
    } dsl_mode_t;
endpackage

// >>> hw/dsl_core.sv
// serial frame receiver, decoder and power-down control of the dac
// assumes frame select, serial clock and data come from outside this clock domain
`timescale 1ns/1ps
`default_nettype none

module dsl_core #(
    parameter bit WIDE = 1'b1,
    parameter int EXIT_CYCLES_P = dsl_pkg::EXIT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic frameSelN,
    input wire logic serialClk,
    input wire logic serialData,
    output logic [dsl_pkg::WIDE_CODE_BITS-1:0] dacCode,
    output dsl_pkg::dsl_mode_t opMode,
    output logic ampEnable,
    output logic outValid,
    output logic loadOpen,
    output logic load100k,
    output logic load1k,
    output logic softReset,
    output logic powerOnHold
);
    import dsl_pkg::*;

    localparam int FRAME_BITS = WIDE ? WIDE_BITS : NARROW_BITS;
    localparam int CODE_BITS = WIDE ? WIDE_CODE_BITS : NARROW_CODE_BITS;
    localparam int MODE_HI = WIDE ? WIDE_MODE_HI : NARROW_MODE_HI;
    localparam int MODE_LO = WIDE ? WIDE_MODE_LO : NARROW_MODE_LO;
    localparam int CNT_W = $clog2(WIDE_BITS + 1);
    localparam int EXIT_W = $clog2(EXIT_CYCLES_P + 1);
    localparam logic [CNT_W-1:0] LAST_COUNT = CNT_W'(FRAME_BITS - 1);
    localparam logic [EXIT_W-1:0] EXIT_LOAD = EXIT_W'(EXIT_CYCLES_P);

    // ****************************************
    // decode helpers
    // ****************************************
    // true for any of the three power-down selector values
    function automatic logic isPowerDown(input dsl_mode_t m);
        return (m != MODE_NORMAL);
    endfunction

    // one load switch per power-down selector value
    function automatic logic selects(input dsl_mode_t m, input dsl_mode_t want);
        return (m == want);
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [1:0] selSync;
    logic [1:0] sclkSync;
    logic [1:0] dataSync;
    logic selLast;
    logic sclkLast;

    // two flops per pin, plus an edge flop on select and clock; the first stage feeds no logic
    always_ff @(posedge clk) begin
        selSync <= {selSync[0], frameSelN};
        sclkSync <= {sclkSync[0], serialClk};
        dataSync <= {dataSync[0], serialData};
        selLast <= selSync[1];
        sclkLast <= sclkSync[1];
    end

    wire logic selLow = ~selSync[1];
    wire logic selRise = selSync[1] & ~selLast;
    wire logic sclkFall = sclkLast & ~sclkSync[1];

    // ****************************************
    // frame shift register and counter
    // ****************************************
    logic [FRAME_BITS-1:0] shiftReg;
    logic [CNT_W-1:0] bitCount;
    logic frameDone;
    logic resetStarted;
    logic onesSoFar;

    // data is shifted msb first on each falling serial clock edge
    wire logic takeBit = selLow & sclkFall & ~frameDone;
    wire logic lastEdge = takeBit & (bitCount == LAST_COUNT);
    wire logic [FRAME_BITS-1:0] fullFrame = {shiftReg[FRAME_BITS-2:0], dataSync[1]};
    wire logic allOnes = &fullFrame;
    wire logic [1:0] newModeBits = fullFrame[MODE_HI:MODE_LO];
    wire logic [CODE_BITS-1:0] newCode = fullFrame[CODE_BITS-1:0];
    // a software reset cannot be cut short once its leading ones are in;
    // every bit so far must be a one, not merely the most recent few
    wire logic prefixOnes = onesSoFar & (bitCount >= CNT_W'(CNT_W));
    // narrow parts ignore the reserved selector rather than guess a load
    wire logic modeOk = WIDE || (newModeBits != MODE_RESERVED_NARROW);

    // counter restarts on every frame select rise
    always_ff @(posedge clk) begin
        if (rst || selRise) begin
            bitCount <= '0;
            shiftReg <= '0;
            frameDone <= 1'b0;
        end else if (takeBit) begin
            shiftReg <= fullFrame;
            bitCount <= bitCount + CNT_W'(1);
            frameDone <= lastEdge;
        end
    end

    // remember a reset pattern so a late abort does not cancel it;
    // a zero bit, the last edge or the rise itself drops the claim,
    // otherwise a later ordinary abort would replay the reset
    always_ff @(posedge clk) begin
        if (rst || lastEdge || selRise) begin
            resetStarted <= 1'b0;
        end else if (takeBit) begin
            resetStarted <= (resetStarted | prefixOnes) & dataSync[1];
        end
    end

    // ones-so-far tracker, restarted with every frame
    always_ff @(posedge clk) begin
        if (rst || selRise) begin
            onesSoFar <= 1'b1;
        end else if (takeBit) begin
            onesSoFar <= onesSoFar & dataSync[1];
        end
    end

    // ****************************************
    // dac register and mode
    // ****************************************
    logic [EXIT_W-1:0] exitCount;
    wire logic finishReset = resetStarted & selRise;
    wire logic doReset = (lastEdge & allOnes) | finishReset;
    wire logic doWrite = lastEdge & ~allOnes & modeOk;
    wire dsl_mode_t nextMode = dsl_mode_t'(newModeBits);
    wire logic leavingPd = doWrite & (nextMode == MODE_NORMAL) & isPowerDown(opMode);

    // code loads only on a whole valid frame; a power-down frame loads its code too
    always_ff @(posedge clk) begin
        if (rst || doReset) begin
            dacCode <= WIDE_CODE_BITS'(CODE_RESET);
            opMode <= MODE_NORMAL;
            powerOnHold <= 1'b1;
        end else if (doWrite) begin
            dacCode <= WIDE_CODE_BITS'(newCode);
            opMode <= nextMode;
            powerOnHold <= 1'b0;
        end
    end

    // one-cycle marker of a completed software reset
    always_ff @(posedge clk) begin
        if (rst) begin
            softReset <= 1'b0;
        end else begin
            softReset <= doReset;
        end
    end

    // ****************************************
    // output stage control
    // ****************************************
    wire logic pdNow = isPowerDown(opMode);

    // exit delay only counts after a power-down is left
    always_ff @(posedge clk) begin
        if (rst) begin
            exitCount <= '0;
        end else if (leavingPd) begin
            exitCount <= EXIT_LOAD;
        end else if (exitCount != '0) begin
            exitCount <= exitCount - EXIT_W'(1);
        end
    end

    // load switches are exclusive; amplifier off in any power-down
    always_ff @(posedge clk) begin
        if (rst) begin
            ampEnable <= 1'b1;
            loadOpen <= 1'b0;
            load100k <= 1'b0;
            load1k <= 1'b0;
            outValid <= 1'b0;
        end else begin
            ampEnable <= ~pdNow;
            loadOpen <= selects(opMode, MODE_PD_OPEN);
            load100k <= selects(opMode, MODE_PD_100K);
            load1k <= selects(opMode, MODE_PD_1K);
            // stays low from power-on until a first valid write lands
            outValid <= ~pdNow & ~leavingPd & (exitCount == '0) & ~powerOnHold;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    // a complete ordinary frame: last edge, not a reset, usable selector
    sequence s_lastBit;
        lastEdge && !allOnes && modeOk;
    endsequence

    // a reset frame finished by its last edge
    sequence s_fullReset;
        lastEdge && allOnes;
    endsequence

    // a reset frame cut short by frame select after its leading ones
    sequence s_cutReset;
        resetStarted && selRise;
    endsequence

    chk_code_load: assert property (@(posedge clk) disable iff (rst)
        s_lastBit |=> dacCode == WIDE_CODE_BITS'($past(newCode)))
        else $error("code not loaded on last edge");

    chk_mode_load: assert property (@(posedge clk) disable iff (rst)
        s_lastBit |=> opMode == $past(nextMode))
        else $error("mode not loaded on last edge");

    chk_abort_keep: assert property (@(posedge clk) disable iff (rst)
        (selRise && !resetStarted && !frameDone) |=> $stable(dacCode) && shiftReg == '0)
        else $error("abort changed state");

    chk_pd_keep: assert property (@(posedge clk) disable iff (rst)
        (pdNow && !doWrite && !doReset) |=> $stable(dacCode))
        else $error("code lost in power-down");

    chk_swreset_zero: assert property (@(posedge clk) disable iff (rst)
        doReset |=> dacCode == '0 && powerOnHold)
        else $error("software reset missed");

    chk_ignore_after: assert property (@(posedge clk) disable iff (rst)
        (frameDone && !selRise) |=> $stable(bitCount))
        else $error("clock counted after frame");

    chk_count_clear: assert property (@(posedge clk) disable iff (rst)
        selRise |=> bitCount == '0)
        else $error("counter not cleared");

    chk_amp_off: assert property (@(posedge clk) disable iff (rst)
        pdNow |=> !ampEnable && !outValid)
        else $error("amplifier on in power-down");

    chk_exit_wait: assert property (@(posedge clk) disable iff (rst)
        leavingPd |=> !outValid [*8])
        else $error("output valid too early");

    // a reserved narrow selector must not move the mode; a reset frame may
    chk_reserved: assert property (@(posedge clk) disable iff (rst)
        (lastEdge && !modeOk && !allOnes) |=> $stable(opMode))
        else $error("reserved mode accepted");

    // ****************************************
    // reset and frame checks
    // ****************************************
    // a full reset frame gives its marker pulse
    chk_reset_pulse: assert property (@(posedge clk) disable iff (rst)
        s_fullReset |=> softReset)
        else $error("soft reset pulse missing");

    // a cut reset frame still completes the reset
    chk_cut_reset: assert property (@(posedge clk) disable iff (rst)
        s_cutReset |=> softReset && dacCode == '0 && opMode == MODE_NORMAL)
        else $error("cut reset frame was aborted");

    // the marker lasts a single cycle
    chk_pulse_once: assert property (@(posedge clk) disable iff (rst)
        softReset |=> !softReset)
        else $error("soft reset pulse too long");

    // every accepted bit lands at the bottom of the shift register
    chk_shift_in: assert property (@(posedge clk) disable iff (rst)
        takeBit |=> shiftReg[0] == $past(dataSync[1]))
        else $error("serial bit not shifted in");

    // every accepted bit advances the counter by one
    chk_count_step: assert property (@(posedge clk) disable iff (rst)
        takeBit |=> bitCount == $past(bitCount) + CNT_W'(1))
        else $error("bit counter did not step");

    // the last edge closes the frame
    chk_done_set: assert property (@(posedge clk) disable iff (rst)
        lastEdge |=> frameDone)
        else $error("frame not closed on last edge");

    // a closed frame stays closed until frame select rises
    chk_done_hold: assert property (@(posedge clk) disable iff (rst)
        (frameDone && !selRise) |=> frameDone)
        else $error("closed frame reopened");

    // ****************************************
    // output stage checks
    // ****************************************
    // power-on level is held while no valid frame has arrived
    chk_hold_invalid: assert property (@(posedge clk) disable iff (rst)
        powerOnHold |=> !outValid)
        else $error("output valid before first write");

    // a valid write ends the power-on hold
    chk_hold_clear: assert property (@(posedge clk) disable iff (rst)
        doWrite |=> !powerOnHold)
        else $error("power-on hold not released");

    // leaving power-down arms the full exit delay
    chk_exit_load: assert property (@(posedge clk) disable iff (rst)
        leavingPd |=> exitCount == EXIT_LOAD)
        else $error("exit delay not armed");

    // no valid output while the exit delay runs
    chk_exit_count: assert property (@(posedge clk) disable iff (rst)
        (exitCount != '0) |=> !outValid)
        else $error("output valid during exit delay");

    // at most one load switch closed at a time
    chk_load_onehot: assert property (@(posedge clk) disable iff (rst)
        $onehot0({loadOpen, load100k, load1k}))
        else $error("two loads selected");

    // the amplifier never drives into a selected load
    chk_amp_loads: assert property (@(posedge clk) disable iff (rst)
        ampEnable |-> !(loadOpen || load100k || load1k))
        else $error("amplifier on with load selected");

    // normal mode turns the amplifier back on
    chk_amp_normal: assert property (@(posedge clk) disable iff (rst)
        !pdNow |=> ampEnable)
        else $error("amplifier off in normal mode");
endmodule // dsl_core

`default_nettype wire

// >>> testbench/dsl_host_model.sv
// host serial port model: drives frame select, serial clock and data
// assumes the bench calls send after reset and never overlaps two frames
`timescale 1ns/1ps
`default_nettype none
module dsl_host_model (
    output logic frameSelN,
    output logic serialClk,
    output logic serialData
);
    // ************
    // frame driver
    // ************
    initial begin
        frameSelN = 1'b1;
        serialClk = 1'b0;
        serialData = 1'b0;
    end
    // msb first; edges below n aborts, above n adds stray clocks
    task automatic send(input logic [23:0] word, input int n, input int edges, input bit idleLow);
        frameSelN = 1'b0;
        #40;
        for (int i = 0; i < edges; i++) begin
            serialClk = 1'b1;
            serialData = (i < n) ? word[n-1-i] : 1'b1;
            #32;
            serialClk = 1'b0;
            #32;
        end
        serialData = ~serialData; // released line must not keep the last bit
        if (idleLow) #400;
        frameSelN = 1'b1;
        #100;
    endtask
endmodule // dsl_host_model
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the dac serial load and power-down logic
// assumes the host model is the only driver of the frame pins
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dsl_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    wire logic fsN, sck, sdi, fsN2, sck2, sdi2;
    logic [15:0] code, nCode, expCode;
    dsl_mode_t mode, nMode, curMode;
    logic ampEnable, outValid, loadOpen, load100k, load1k, softReset, powerOnHold;
    int fails = 0;
    int totalChecks = 0;
    int seed = 27510;
    int pulses = 0;
    int base;
    always #2.5 clk = ~clk;
    // soft reset pulses are counted, since a single cycle is easy to miss
    always @(posedge clk) if (softReset === 1'b1) pulses <= pulses + 1;
    dsl_host_model host (.frameSelN(fsN), .serialClk(sck), .serialData(sdi));
    dsl_host_model host2 (.frameSelN(fsN2), .serialClk(sck2), .serialData(sdi2));
    dsl_core #(.WIDE(1'b1), .EXIT_CYCLES_P(10)) dut (.clk(clk), .rst(rst), .frameSelN(fsN),
        .serialClk(sck), .serialData(sdi), .dacCode(code), .opMode(mode),
        .ampEnable(ampEnable), .outValid(outValid), .loadOpen(loadOpen), .load100k(load100k),
        .load1k(load1k), .softReset(softReset), .powerOnHold(powerOnHold));
    dsl_core #(.WIDE(1'b0), .EXIT_CYCLES_P(10)) dut_narrow (.clk(clk), .rst(rst),
        .frameSelN(fsN2), .serialClk(sck2), .serialData(sdi2), .dacCode(nCode), .opMode(nMode),
        .ampEnable(), .outValid(), .loadOpen(), .load100k(), .load1k(), .softReset(),
        .powerOnHold());
    // ***************
    // compare helpers
    // ***************
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask
    task automatic chk_state(input dsl_mode_t m, input logic [15:0] c);
        chk_val(code, c);
        chk_val({14'h0000, mode}, {14'h0000, m});
        chk_bit(ampEnable, m == MODE_NORMAL);
        chk_bit(outValid, m == MODE_NORMAL);
        chk_bit(loadOpen, m == MODE_PD_OPEN);
        chk_bit(load100k, m == MODE_PD_100K);
        chk_bit(load1k, m == MODE_PD_1K);
    endtask
    // wide frame image: six zero bits, mode selector, sixteen code bits
    function automatic logic [23:0] frame_word(input dsl_mode_t m, input logic [15:0] c);
        return {6'h00, m, c};
    endfunction
    // narrow frame image in the low sixteen bits
    function automatic logic [23:0] narrow_word(input dsl_mode_t m, input logic [13:0] c);
        return {8'h00, m, c};
    endfunction
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ********
    // sequence
    // ********
    initial begin
        #300000;
        fails++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk_val(code, 16'h0000);
        chk_bit(powerOnHold, 1'b1);
        chk_bit(outValid, 1'b0);
        expCode = 16'h0000;
        // cycle all modes; power-down frames resend the held code
        for (int i = 0; i < 13; i++) begin
            curMode = dsl_mode_t'(i % 4);
            if (curMode == MODE_NORMAL) expCode = 16'($random(seed));
            @(posedge clk) #1;
            host.send(frame_word(curMode, expCode), 24, 24 + i % 3, i[0]);
            repeat (20) @(posedge clk);
            #1;
            chk_state(curMode, expCode);
        end
        host.send(frame_word(MODE_PD_100K, ~expCode), 24, 10, 1'b0);
        repeat (20) @(posedge clk);
        #1;
        chk_state(MODE_NORMAL, expCode);
        // full and early-ended soft reset must both clear the code
        for (int s = 24; s >= 12; s -= 12) begin
            host.send(frame_word(MODE_NORMAL, 16'h2AAA), 24, 24, 1'b0);
            repeat (20) @(posedge clk);
            #1;
            chk_val(code, 16'h2AAA);
            base = pulses;
            host.send(24'hFF_FFFF, 24, s, 1'b0);
            repeat (20) @(posedge clk);
            #1;
            chk_val(code, 16'h0000);
            chk_val({14'h0000, mode}, 16'h0000);
            chk_bit(powerOnHold, 1'b1);
            chk_val(16'(pulses - base), 16'h0001);
        end
        host2.send(narrow_word(MODE_NORMAL, 14'h1A5C), 16, 16, 1'b0);
        repeat (20) @(posedge clk);
        #1;
        chk_val(nCode, 16'h1A5C);
        host2.send(narrow_word(MODE_PD_1K, 14'h0123), 16, 16, 1'b0);
        repeat (20) @(posedge clk);
        #1;
        chk_val(nCode, 16'h1A5C);
        host2.send(narrow_word(MODE_PD_OPEN, 14'h1A5C), 16, 16, 1'b0);
        repeat (20) @(posedge clk);
        #1;
        chk_val({14'h0000, nMode}, 16'h0001);
        end_sim();
    end
endmodule // tb
`default_nettype wire
